//--- design/sbfc_cfg.svh
// Offsets, field positions, reset values and timing counts of the bridge controller
`ifndef SBFC_CFG_SVH
`define SBFC_CFG_SVH
`define SBFC_CTRL_OFS        12'h000
`define SBFC_STATUS_OFS      12'h004
`define SBFC_CTRL_RST        32'h0000_0001
`define SBFC_CTRL_MIX_BIT    0
`define SBFC_ST_THERM_BIT    0
`define SBFC_ST_OC_BIT       1
`define SBFC_ST_UNDERVOLTAGE_LOCKOUT_BIT     2
`define SBFC_ST_STBY_BIT     3
`define SBFC_ST_INIT_BIT     4
`define SBFC_ST_POS_LSB      8
`define SBFC_ST_MODE_LSB     16
`define SBFC_CLK_MHZ         200
`define SBFC_MCLK_MHZ        4
`define SBFC_CHOP_DIV_MCLK   20
`define SBFC_CHOP_DIV        (`SBFC_CLK_MHZ / `SBFC_MCLK_MHZ * `SBFC_CHOP_DIV_MCLK)
`define SBFC_CHOP_TICKS      5
`define SBFC_FAST_TICKS      2
`define SBFC_DEAD_NS         300
`define SBFC_DEAD_CYC        ((`SBFC_DEAD_NS * `SBFC_CLK_MHZ + 999) / 1000)
`define SBFC_OC_MASK_NS      4000
`define SBFC_OC_MASK_CYC     ((`SBFC_OC_MASK_NS * `SBFC_CLK_MHZ + 999) / 1000)
`define SBFC_POS_INIT        6'h00
`define SBFC_POS_INIT_FULL   6'h38
`endif

//--- design/sbfc_pkg.sv
// Types of the stepper bridge and fault controller
package sbfc_pkg;
   typedef enum logic [1:0] {
      BR_OFF    = 2'h0,
      BR_CHARGE = 2'h1,
      BR_SLOW   = 2'h3,
      BR_FAST   = 2'h2
   } sbfc_bridge_t;

   typedef enum logic [2:0] {
      MODE_STBY_LO   = 3'h0,
      MODE_FULL      = 3'h1,
      MODE_HALF_A    = 3'h2,
      MODE_HALF_B    = 3'h3,
      MODE_QUARTER   = 3'h4,
      MODE_EIGHTH    = 3'h5,
      MODE_SIXTEENTH = 3'h6,
      MODE_STBY_HI   = 3'h7
   } sbfc_mode_t;

   typedef struct packed {
      logic highSide1;
      logic highSide2;
      logic lowSide1;
      logic lowSide2;
   } sbfc_gate_t;

   typedef struct packed {
      logic       stepClk;
      logic       rotationDirection;
      logic       enable;
      logic       stepReset_n;
      logic [2:0] stepSel;
      logic       recoverAuto;
      logic       overTemp;
      logic [7:0] overCurrent;
      logic       supplyBelow8v;
      logic       undervoltageLockout;
      logic [1:0] currentThresholdHit;
   } sbfc_pins_t;
endpackage

//--- design/sbfc_bridge_ctrl.sv
// Stepper bridge switching, chopping, sequencing and protection logic
//
// The register offsets and register access over APB are this design's own decisions.
`timescale 1ns/1ps
`include "sbfc_cfg.svh"

module sbfc_bridge_ctrl #(
   parameter int unsigned CHOP_DIV       = `SBFC_CHOP_DIV,    // Clocks per chop tick
   parameter int unsigned DEAD_CYCLES    = `SBFC_DEAD_CYC,    // Dead time in clocks
   parameter int unsigned OC_MASK_CYCLES = `SBFC_OC_MASK_CYC  // Overcurrent mask in clocks
) (
   input  wire logic                        clk_sys,                // 200 MHz clock
   input  wire logic                        reset_n,                // Power-up reset
   input  wire logic [11:0]                 paddr,                  // APB address
   input  wire logic                        psel,                   // APB select
   input  wire logic                        penable,                // APB enable
   input  wire logic                        pwrite,                 // APB direction
   input  wire logic [31:0]                 pwdata,                 // APB write data
   output logic                             pready,                 // APB ready
   output logic [31:0]                      prdata,                 // APB read data
   output logic                             pslverr,                // APB error
   input  wire logic                        stepClk,                // Step clock pin
   input  wire logic                        rotationDirection,      // Direction pin
   input  wire logic                        enable,                 // Output enable pin
   input  wire logic                        stepReset_n,            // Position reset pin
   input  wire logic                        stepSelBit2,            // Step-mode select
   input  wire logic                        stepSelBit1,            // Step-mode select
   input  wire logic                        stepSelBit0,            // Step-mode select
   input  wire logic                        recoverAuto,            // Thermal recovery select
   input  wire logic                        overTemp,               // Over-temperature comp
   input  wire logic [7:0]                  overCurrent,            // Per-transistor OC comp
   input  wire logic                        supplyBelow8v,          // Supply below 8 V comp
   input  wire logic                        undervoltageLockout,    // UNDERVOLTAGE_LOCKOUT comp
   input  wire logic [1:0]                  currentThresholdHit,    // Per-phase current comp
   output sbfc_pkg::sbfc_gate_t [1:0]       bridgeGate,             // Gate drive per phase
   output logic [1:0][4:0]                  phaseLevel,             // Current level index
   output logic [1:0]                       phaseReverse,           // Reverse current sign
   input  wire logic                        faultFlagIn,            // Fault pin level
   output logic                             faultFlagOut,           // Fault pin drive value
   output logic                             faultFlagOe_n,          // Fault pin drive enable
   input  wire logic                        initialPositionFlagIn,  // Init pin level
   output logic                             initialPositionFlagOut, // Init pin drive value
   output logic                             initialPositionFlagOe_n // Init pin drive enable
);

   localparam logic [9:0] DIV_LAST  = 10'(CHOP_DIV - 1);
   localparam logic [6:0] DEAD_LD   = 7'(DEAD_CYCLES);
   localparam logic [9:0] OC_LD     = 10'(OC_MASK_CYCLES);
   localparam logic [2:0] TICK_LAST = 3'(`SBFC_CHOP_TICKS - 1);
   localparam logic [2:0] TICK_FAST = 3'(`SBFC_CHOP_TICKS - `SBFC_FAST_TICKS);
   // Pin synchronisers
   sbfc_pkg::sbfc_pins_t pinRaw;
   sbfc_pkg::sbfc_pins_t sync1_reg;
   sbfc_pkg::sbfc_pins_t sync2_reg;
   sbfc_pkg::sbfc_pins_t sync3_reg;
   sbfc_pkg::sbfc_pins_t pin_reg;
   sbfc_pkg::sbfc_pins_t pin_next;
   sbfc_pkg::sbfc_pins_t agree;
   assign pinRaw = '{stepClk:             stepClk,
                     rotationDirection:   rotationDirection,
                     enable:              enable,
                     stepReset_n:         stepReset_n,
                     stepSel:             {stepSelBit2, stepSelBit1, stepSelBit0},
                     recoverAuto:         recoverAuto,
                     overTemp:            overTemp,
                     overCurrent:         overCurrent,
                     supplyBelow8v:       supplyBelow8v,
                     undervoltageLockout: undervoltageLockout,
                     currentThresholdHit: currentThresholdHit};
   assign agree    = ~(sync2_reg ^ sync3_reg);
   assign pin_next = (sync2_reg & agree) | (pin_reg & ~agree);
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         sync1_reg <= '0;
         sync2_reg <= '0;
         sync3_reg <= '0;
         pin_reg   <= '0;
      end else begin
         sync1_reg <= pinRaw;
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
         pin_reg   <= pin_next;
      end
   end

   // Edge detection and mode decode
   logic       stepPrev_reg;
   logic       enPrev_reg;
   logic [2:0] modePrev_reg;
   wire        stepRise   = pin_reg.stepClk & ~stepPrev_reg;
   wire        enRise     = pin_reg.enable & ~enPrev_reg;
   wire  [2:0] modeSel    = pin_reg.stepSel;
   wire        modeChange = modeSel != modePrev_reg;
   wire        standby    = (modeSel == sbfc_pkg::MODE_STBY_LO) ||
                            (modeSel == sbfc_pkg::MODE_STBY_HI);
   wire        undervoltage_lockout       = pin_reg.undervoltageLockout;
   logic [5:0] stepSize;
   wire  [5:0] initPos    = (modeSel == sbfc_pkg::MODE_FULL) ?
                            `SBFC_POS_INIT_FULL : `SBFC_POS_INIT;
   always_comb begin
      case (modeSel)
         sbfc_pkg::MODE_FULL:      stepSize = 6'h10;
         sbfc_pkg::MODE_HALF_A:    stepSize = 6'h08;
         sbfc_pkg::MODE_HALF_B:    stepSize = 6'h08;
         sbfc_pkg::MODE_QUARTER:   stepSize = 6'h04;
         sbfc_pkg::MODE_EIGHTH:    stepSize = 6'h02;
         sbfc_pkg::MODE_SIXTEENTH: stepSize = 6'h01;
         default:                  stepSize = 6'h00;
      endcase
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         stepPrev_reg <= 1'b0;
         enPrev_reg   <= 1'b0;
         modePrev_reg <= 3'h0;
      end else begin
         stepPrev_reg <= pin_reg.stepClk;
         enPrev_reg   <= pin_reg.enable;
         modePrev_reg <= modeSel;
      end
   end

   // Step sequencer, 64 positions per electrical turn
   logic [5:0] pos_reg;
   logic [5:0] pos_next;
   always_comb begin
      pos_next = pos_reg;
      if (undervoltage_lockout || !pin_reg.stepReset_n || modeChange) begin
         pos_next = initPos;
      end else if (stepRise && !standby) begin
         if (pin_reg.rotationDirection) begin
            pos_next = pos_reg - stepSize;
         end else begin
            pos_next = pos_reg + stepSize;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         pos_reg <= `SBFC_POS_INIT;
      end else begin
         pos_reg <= pos_next;
      end
   end

   // Chop timing
   logic [9:0] divCnt_reg;
   logic [2:0] tickIdx_reg;
   wire        chopTick         = divCnt_reg == DIV_LAST;
   wire        periodStart      = chopTick && (tickIdx_reg == TICK_LAST);
   wire        decaySwitchPoint = chopTick && (tickIdx_reg == TICK_FAST - 3'h1);
   wire        pastSwitch       = tickIdx_reg >= TICK_FAST;
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         divCnt_reg  <= 10'h000;
         tickIdx_reg <= 3'h0;
      end else begin
         divCnt_reg <= chopTick ? 10'h000 : divCnt_reg + 10'h001;
         if (chopTick) begin
            tickIdx_reg <= periodStart ? 3'h0 : tickIdx_reg + 3'h1;
         end
      end
   end

   // Protection
   logic       thermalShutdown_reg;
   logic       overcurrentShutdown_reg;
   logic [9:0] ocCnt_reg;
   logic [1:0] recCnt_reg;
   wire        autoMode  = pin_reg.recoverAuto | standby;
   wire        ocSeen    = (|pin_reg.overCurrent) && !standby;
   wire        ocTrip    = ocSeen && (ocCnt_reg == OC_LD);
   wire        thermSet  = pin_reg.overTemp && !pin_reg.supplyBelow8v;
   wire        autoClear = autoMode && periodStart && (recCnt_reg == 2'h1) &&
                           !pin_reg.overTemp;
   wire        latchClear = !autoMode && enRise && !pin_reg.overTemp;
   wire        thermNext = thermSet | (thermalShutdown_reg & ~(autoClear | latchClear));
   wire        ocNext    = ocTrip | (overcurrentShutdown_reg & ~enRise);
   wire        run       = pin_reg.enable && !standby && !undervoltage_lockout &&
                           !thermalShutdown_reg && !overcurrentShutdown_reg;
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         ocCnt_reg <= 10'h000;
      end else if (!ocSeen) begin
         ocCnt_reg <= 10'h000;
      end else if (ocCnt_reg != OC_LD) begin
         ocCnt_reg <= ocCnt_reg + 10'h001;
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         recCnt_reg <= 2'h0;
      end else if (!thermalShutdown_reg || pin_reg.overTemp) begin
         recCnt_reg <= 2'h0;
      end else if (autoMode && periodStart && recCnt_reg != 2'h3) begin
         recCnt_reg <= recCnt_reg + 2'h1;
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         thermalShutdown_reg     <= 1'b0;
         overcurrentShutdown_reg <= 1'b0;
      end else begin
         thermalShutdown_reg     <= thermNext;
         overcurrentShutdown_reg <= ocNext;
      end
   end

   // Control register
   logic [31:0] ctrl_reg;
   wire         mixedDecay = ctrl_reg[`SBFC_CTRL_MIX_BIT];
   // Per-phase signed level: {reverse, magnitude}
   function automatic logic [5:0] levelOf(input logic [5:0] p);
      logic [4:0] mag;
      mag = p[4] ? {1'b0, p[3:0]} : 5'h10 - {1'b0, p[3:0]};
      levelOf = {(p[5] ^ p[4]) && (mag != 5'h00), mag};
   endfunction
   function automatic sbfc_pkg::sbfc_gate_t gateOf(input sbfc_pkg::sbfc_bridge_t s,
                                                   input logic rev);
      case (s)
         sbfc_pkg::BR_CHARGE: gateOf = rev ? 4'h6 : 4'h9;
         sbfc_pkg::BR_SLOW:   gateOf = 4'h3;
         sbfc_pkg::BR_FAST:   gateOf = rev ? 4'h9 : 4'h6;
         default:             gateOf = 4'h0;
      endcase
   endfunction

   genvar ph;
   generate
      for (ph = 0; ph < 2; ph = ph + 1) begin : g_phase
         sbfc_pkg::sbfc_bridge_t br_reg;
         sbfc_pkg::sbfc_bridge_t br_next;
         sbfc_pkg::sbfc_gate_t   gate_reg;
         sbfc_pkg::sbfc_gate_t   target;
         logic [6:0]             dead_reg;
         logic [5:0]             lvl_reg;
         wire  [5:0]             lvl = levelOf(pos_reg - 6'(ph * 16));
         wire                    hit = pin_reg.currentThresholdHit[ph];
         always_comb begin
            br_next = br_reg;
            if (!run) begin
               br_next = sbfc_pkg::BR_OFF;
            end else if (periodStart) begin
               br_next = sbfc_pkg::BR_CHARGE;
            end else begin
               case (br_reg)
                  sbfc_pkg::BR_CHARGE: begin
                     if (hit) begin
                        br_next = (pastSwitch && mixedDecay) ?
                                  sbfc_pkg::BR_FAST : sbfc_pkg::BR_SLOW;
                     end
                  end
                  sbfc_pkg::BR_SLOW: begin
                     if (decaySwitchPoint && mixedDecay) begin
                        br_next = sbfc_pkg::BR_FAST;
                     end
                  end
                  sbfc_pkg::BR_FAST: br_next = sbfc_pkg::BR_FAST;
                  default:           br_next = sbfc_pkg::BR_OFF;
               endcase
            end
         end

         // Zero current holds the coil in slow decay
         assign target = (br_reg != sbfc_pkg::BR_OFF && lvl[4:0] == 5'h00) ?
                         gateOf(sbfc_pkg::BR_SLOW, 1'b0) : gateOf(br_reg, lvl[5]);

         always_ff @(posedge clk_sys or negedge reset_n) begin
            if (!reset_n) begin
               br_reg  <= sbfc_pkg::BR_OFF;
               lvl_reg <= 6'h00;
            end else begin
               br_reg  <= br_next;
               lvl_reg <= lvl;
            end
         end

         always_ff @(posedge clk_sys or negedge reset_n) begin
            if (!reset_n) begin
               gate_reg <= '0;
               dead_reg <= 7'h00;
            end else if (!run) begin
               gate_reg <= '0;
               dead_reg <= 7'h00;
            end else if (dead_reg != 7'h00) begin
               dead_reg <= dead_reg - 7'h01;
               if (dead_reg == 7'h01) begin
                  gate_reg <= target;
               end
            end else if (target != gate_reg) begin
               gate_reg <= gate_reg & target;
               dead_reg <= DEAD_LD;
            end
         end

         assign bridgeGate[ph]   = gate_reg;
         assign phaseLevel[ph]   = lvl_reg[4:0];
         assign phaseReverse[ph] = lvl_reg[5];
      end
   endgenerate

   // Open-drain flags, driven low with enable active low
   logic faultOe_n_reg;
   logic initOe_n_reg;
   wire  atInit = (pos_reg == initPos) && !standby;

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         faultOe_n_reg <= 1'b1;
         initOe_n_reg  <= 1'b1;
      end else begin
         faultOe_n_reg <= ~(thermalShutdown_reg | overcurrentShutdown_reg);
         initOe_n_reg  <= ~atInit;
      end
   end

   assign faultFlagOut            = 1'b0;
   assign faultFlagOe_n           = faultOe_n_reg;
   assign initialPositionFlagOut  = 1'b0;
   assign initialPositionFlagOe_n = initOe_n_reg;

   // APB slave, zero wait states
   logic [31:0] rdata_reg;
   wire         hitCtrl   = paddr == `SBFC_CTRL_OFS;
   wire         hitStatus = paddr == `SBFC_STATUS_OFS;
   wire         mapped    = hitCtrl | hitStatus;
   wire         access    = psel & penable;
   wire         ctrlWrite = access & pwrite & hitCtrl;
   logic [31:0] status;
   logic [31:0] readMux;
   always_comb begin
      status = 32'h0000_0000;
      status[`SBFC_ST_THERM_BIT] = thermalShutdown_reg;
      status[`SBFC_ST_OC_BIT]    = overcurrentShutdown_reg;
      status[`SBFC_ST_UNDERVOLTAGE_LOCKOUT_BIT]  = undervoltage_lockout;
      status[`SBFC_ST_STBY_BIT]  = standby;
      status[`SBFC_ST_INIT_BIT]  = atInit;
      status[`SBFC_ST_POS_LSB +: 6]  = pos_reg;
      status[`SBFC_ST_MODE_LSB +: 3] = modeSel;
   end

   assign readMux = hitCtrl ? ctrl_reg : (hitStatus ? status : 32'h0000_0000);

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         ctrl_reg  <= `SBFC_CTRL_RST;
         rdata_reg <= 32'h0000_0000;
      end else begin
         if (ctrlWrite) begin
            ctrl_reg <= {31'h0000_0000, pwdata[`SBFC_CTRL_MIX_BIT]};
         end
         if (psel && !penable) begin
            rdata_reg <= readMux;
         end
      end
   end

   assign pready  = 1'b1;
   assign prdata  = rdata_reg;
   assign pslverr = access & ~mapped;

endmodule

//--- verification/sbfc_bridge_ctrl_sva.sv
// Port assertions of the bridge and fault controller
`timescale 1ns/1ps
module sbfc_bridge_ctrl_sva #(
   parameter int unsigned OC_MASK_CYCLES = 8 // Overcurrent mask in clocks
) (
   input wire logic                       clk_sys,             // Clock
   input wire logic                       reset_n,             // Reset
   input wire logic                       enable,              // Enable pin
   input wire logic                       stepSelBit2,         // Mode select
   input wire logic                       stepSelBit1,         // Mode select
   input wire logic                       stepSelBit0,         // Mode select
   input wire logic                       recoverAuto,         // Recovery select
   input wire logic                       overTemp,            // Over-temperature
   input wire logic [7:0]                 overCurrent,         // Overcurrent
   input wire logic                       supplyBelow8v,       // Low supply
   input wire logic                       undervoltageLockout, // Lockout
   input wire sbfc_pkg::sbfc_gate_t [1:0] bridgeGate,          // Gates
   input wire logic                       faultFlagOe_n        // Fault drive
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   logic [7:0] ocRun, ocAge, otAge, sbRun, sbyRun;
   wire        stby = (stepSelBit2 == stepSelBit1) && (stepSelBit1 == stepSelBit0);
   wire        shoot = |((bridgeGate[0][3:2] & bridgeGate[0][1:0])
                       | (bridgeGate[1][3:2] & bridgeGate[1][1:0]));
   // Saturating run length of a condition
   function automatic logic [7:0] run(input logic c, input logic [7:0] n);
      return c ? ((n == 8'hFF) ? n : n + 8'h01) : 8'h00;
   endfunction
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         {ocRun, ocAge, otAge, sbRun, sbyRun} <= '0;
      end else begin
         {ocRun, ocAge} <= {run(|overCurrent, ocRun), run(~|overCurrent, ocAge)};
         {otAge, sbRun} <= {run(!overTemp, otAge), run(supplyBelow8v, sbRun)};
         sbyRun <= run(stby, sbyRun);
      end
   end
   property p_no_shoot;
      !shoot;
   endproperty
   a_no_shoot: assert property (p_no_shoot) else $error("shoot-through gate pair");
   property p_en_off;
      !enable [*8] |-> bridgeGate == '0;
   endproperty
   a_en_off: assert property (p_en_off) else $error("gates on while disabled");
   property p_undervoltage_lockout_off;
      undervoltageLockout [*8] |-> bridgeGate == '0;
   endproperty
   a_undervoltage_lockout_off: assert property (p_undervoltage_lockout_off) else $error("gates on in lockout");
   property p_fault_off;
      !faultFlagOe_n && $past(!faultFlagOe_n) |-> bridgeGate == '0;
   endproperty
   a_fault_off: assert property (p_fault_off) else $error("gates on in shutdown");
   property p_oc_mask;
      $fell(faultFlagOe_n) |-> ocRun >= OC_MASK_CYCLES || otAge < 8;
   endproperty
   a_oc_mask: assert property (p_oc_mask) else $error("short overcurrent latched");
   property p_oc_stby;
      sbyRun >= 8 && otAge >= 8 && faultFlagOe_n |=> faultFlagOe_n;
   endproperty
   a_oc_stby: assert property (p_oc_stby) else $error("overcurrent in standby");
   property p_low_supply;
      sbRun >= 8 && ocAge >= 8 && faultFlagOe_n |=> faultFlagOe_n;
   endproperty
   a_low_supply: assert property (p_low_supply) else $error("thermal at low supply");
   property p_latch_hold;
      (enable && !recoverAuto && !stby) [*8] ##0 !faultFlagOe_n |=> !faultFlagOe_n;
   endproperty
   a_latch_hold: assert property (p_latch_hold) else $error("latched fault left");
endmodule
bind sbfc_bridge_ctrl sbfc_bridge_ctrl_sva #(.OC_MASK_CYCLES(OC_MASK_CYCLES)) u_sva (
   .clk_sys, .reset_n, .enable, .stepSelBit2, .stepSelBit1, .stepSelBit0, .recoverAuto,
   .overTemp, .overCurrent, .supplyBelow8v, .undervoltageLockout, .bridgeGate, .faultFlagOe_n);

//--- verification/sbfc_host_model.sv
// Host motion controller model for step, direction and enable
`timescale 1ns/1ps
module sbfc_host_model #(
   parameter int unsigned ENLOW_CYC = 60000 // Enable low hold in clocks
) (
   input  wire logic clk_sys,           // Clock
   output logic      stepClk,           // Step pin
   output logic      rotationDirection, // Direction pin
   output logic      enable             // Enable pin
);
   initial begin
      {stepClk, rotationDirection, enable} = 3'h0;
   end
   task automatic step(input logic dir);
      @(posedge clk_sys) rotationDirection <= dir;
      repeat (6) @(posedge clk_sys);
      stepClk <= 1'b1;
      repeat (6) @(posedge clk_sys);
      stepClk <= 1'b0;
      repeat (6) @(posedge clk_sys);
   endtask
   task automatic set_en(input logic v);
      @(posedge clk_sys) enable <= v;
   endtask
   task automatic clear_fault;
      set_en(1'b0);
      repeat (ENLOW_CYC) @(posedge clk_sys);
      set_en(1'b1);
   endtask
endmodule

//--- verification/sbfc_bridge_ctrl_tb.sv
// Self-checking bench of the bridge and fault controller
`timescale 1ns/1ps
module sbfc_bridge_ctrl_tb;
   logic        clk_sys = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata;
   logic        pready, pslverr, stepClk, rotationDirection, enable, stepReset_n = 1'b1;
   logic        stepSelBit2 = 1'b0, stepSelBit1 = 1'b0, stepSelBit0 = 1'b1;
   logic        recoverAuto = 1'b0, overTemp = 1'b0, supplyBelow8v = 1'b0;
   logic        undervoltageLockout = 1'b0, faultFlagOut, faultFlagOe_n;
   logic        initialPositionFlagOut, initialPositionFlagOe_n;
   logic [7:0]  overCurrent = 8'h00;
   logic [1:0]  currentThresholdHit = 2'h0, phaseReverse;
   logic [1:0][4:0] phaseLevel;
   sbfc_pkg::sbfc_gate_t [1:0] bridgeGate;
   wire         faultFlagIn = faultFlagOe_n ? 1'b1 : faultFlagOut;
   wire         initialPositionFlagIn = initialPositionFlagOe_n ? 1'b1 : initialPositionFlagOut;
   int          n_fail = 0, n_checks = 0;
   sbfc_bridge_ctrl #(.CHOP_DIV(10), .DEAD_CYCLES(4), .OC_MASK_CYCLES(8)) dut (
      .clk_sys, .reset_n, .paddr, .psel, .penable, .pwrite, .pwdata, .pready, .prdata,
      .pslverr, .stepClk, .rotationDirection, .enable, .stepReset_n, .stepSelBit2,
      .stepSelBit1, .stepSelBit0, .recoverAuto, .overTemp, .overCurrent, .supplyBelow8v,
      .undervoltageLockout, .currentThresholdHit, .bridgeGate, .phaseLevel, .phaseReverse,
      .faultFlagIn, .faultFlagOut, .faultFlagOe_n, .initialPositionFlagIn,
      .initialPositionFlagOut, .initialPositionFlagOe_n);
   // Enable low hold shortened 1000 times, the chop clock only 100 times
   sbfc_host_model #(.ENLOW_CYC(60)) host (.clk_sys, .stepClk, .rotationDirection, .enable);
   initial begin
      forever #2.5 clk_sys = ~clk_sys;
   end
   task automatic summarize;
      if (n_fail == 0 && n_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, output logic [31:0] q,
                      input logic [31:0] d = 32'h0);
      int i;
      @(posedge clk_sys);
      {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
      @(posedge clk_sys);
      penable <= 1'b1;
      i = 0;
      do begin
         @(posedge clk_sys);
         i++;
      end while (pready !== 1'b1 && i < 50);
      q = pslverr ? 32'hFFFF_FFFF : prdata;
      {psel, penable} <= 2'h0;
      chk(i < 50, 1'b1);
      if (i >= 50) summarize();
   endtask
   task automatic wait_gate(input logic [3:0] v, input logic eq);
      int i;
      i = 0;
      while ((bridgeGate[0] === v) !== eq && i < 400) begin
         @(negedge clk_sys);
         i++;
      end
      if (i >= 400) chk(bridgeGate[0], v);
      if (i >= 400) summarize();
      @(posedge clk_sys);
   endtask
   task automatic t_modes;
      logic [31:0] q;
      apb(1'b0, 12'h000, q);
      chk(q, 32'h1);
      apb(1'b0, 12'h008, q);
      chk(q, 32'hFFFF_FFFF);
      apb(1'b1, 12'h000, q, 32'hFFFF_FFFE);
      apb(1'b0, 12'h000, q);
      chk(q, 32'h0);
      apb(1'b1, 12'h000, q, 32'h1);
      for (int m = 0; m < 8; m++) begin
         {stepSelBit2, stepSelBit1, stepSelBit0} <= 3'(m);
         repeat (10) @(posedge clk_sys);
         apb(1'b0, 12'h004, q);
         chk({q[18:16], q[3]}, {3'(m), m == 0 || m == 7});
         if (m != 0 && m != 7) chk(q[13:8], (m == 1) ? 6'h38 : 6'h00);
      end
      {stepSelBit2, stepSelBit1, stepSelBit0} <= 3'h1;
      repeat (10) @(posedge clk_sys);
   endtask
   task automatic t_step;
      logic [31:0] q;
      chk(initialPositionFlagIn, 1'b0);
      host.step(1'b0);
      apb(1'b0, 12'h004, q);
      chk({q[13:8], initialPositionFlagIn}, {6'h08, 1'b1});
      host.step(1'b1);
      apb(1'b0, 12'h004, q);
      chk(q[13:8], 6'h38);
   endtask
   task automatic t_chop;
      host.set_en(1'b1);
      wait_gate(4'h9, 1'b1);
      chk({phaseLevel, phaseReverse, bridgeGate[1]}, {10'h108, 2'b10, 4'h6});
      currentThresholdHit <= 2'h1;
      wait_gate(4'h9, 1'b0);
      chk(bridgeGate[0], 4'h1);
      wait_gate(4'h3, 1'b1);
      wait_gate(4'h6, 1'b1);
      currentThresholdHit <= 2'h0;
      wait_gate(4'h9, 1'b1);
      repeat (33) @(posedge clk_sys);
      currentThresholdHit <= 2'h1;
      wait_gate(4'h9, 1'b0);
      chk(bridgeGate[0], 4'h0);
      wait_gate(4'h6, 1'b1);
      currentThresholdHit <= 2'h0;
   endtask
   task automatic t_faults;
      overCurrent <= 8'h01;
      repeat (4) @(posedge clk_sys);
      overCurrent <= 8'h00;
      repeat (10) @(posedge clk_sys);
      chk(faultFlagIn, 1'b1);
      overCurrent <= 8'h80;
      repeat (30) @(posedge clk_sys);
      {overCurrent, recoverAuto} <= 9'h001;
      repeat (200) @(posedge clk_sys);
      chk({faultFlagIn, bridgeGate}, 9'h000);
      host.clear_fault();
      {overTemp, recoverAuto} <= 2'h2;
      repeat (10) @(posedge clk_sys);
      chk(faultFlagIn, 1'b0);
      host.clear_fault();
      repeat (10) @(posedge clk_sys);
      chk(faultFlagIn, 1'b0);
      overTemp <= 1'b0;
      repeat (200) @(posedge clk_sys);
      chk(faultFlagIn, 1'b0);
      host.clear_fault();
      {overTemp, recoverAuto} <= 2'h3;
      repeat (10) @(posedge clk_sys);
      overTemp <= 1'b0;
      repeat (30) @(posedge clk_sys);
      chk(faultFlagIn, 1'b0);
      repeat (90) @(posedge clk_sys);
      chk(faultFlagIn, 1'b1);
      {overTemp, supplyBelow8v} <= 2'h3;
      repeat (20) @(posedge clk_sys);
      chk(faultFlagIn, 1'b1);
      {overTemp, supplyBelow8v} <= 2'h0;
   endtask
   task automatic t_undervoltage_lockout;
      logic [31:0] q;
      host.step(1'b0);
      stepReset_n <= 1'b0;
      repeat (10) @(posedge clk_sys);
      apb(1'b0, 12'h004, q);
      chk(q[13:8], 6'h38);
      stepReset_n <= 1'b1;
      host.step(1'b0);
      undervoltageLockout <= 1'b1;
      repeat (10) @(posedge clk_sys);
      apb(1'b0, 12'h004, q);
      chk({q[13:8], bridgeGate}, {6'h38, 8'h00});
      undervoltageLockout <= 1'b0;
   endtask
   initial begin
      repeat (3) @(posedge clk_sys);
      reset_n <= 1'b1;
      chk({bridgeGate, faultFlagIn}, 9'h001);
      t_modes();
      t_step();
      t_chop();
      t_faults();
      t_undervoltage_lockout();
      summarize();
   end
endmodule
